// ==== hw/core_pointer_config_registers.sv ====
// Notes on behaviour
// RULE1: data pointer is high byte over low byte, all zero after reset.
// RULE2: low stack register holds stack bits 7..0, resets to zero.
// RULE3: stack high bits 2..0 hold stack bits 10..8, reset value 001.
// RULE4: stack high bits 5..3 hold stack base bits 10..8, reset value 001.
// RULE5: software always writes one to stack high bit 7; it resets to one.
// RULE6: guard register bits 7..3 hold waterline setting, reset zero.
// RULE7: guard bit 2 picks violation response: zero interrupt, one reset.
// RULE8: software keeps setup bit 7 at one; it resets to one.
// RULE9: setup bit 6 enables the enhanced error-checking UART.
// RULE10: setup bit 5 gives shared serial pins to I2C (0) or SPI (1).
// RULE11: setup bit 4 enables 38 kHz modulation on selected pins.
// RULE12: software keeps setup bits 3..2 at zero.
// RULE13: either setup bit 1 or 0 set enables 256-byte external RAM moves.
// RULE14: program counter clears on reset, advances by instruction length.
// RULE15: program counter not a register; changes only by advance or jump.
// RULE16: current opcode held in an internal, software-invisible register.
// RULE17: four banks of eight byte registers in the lowest 32 RAM bytes.
// RULE18: status word bits 4..3 select the active bank.
// RULE19: bank operand takes one cycle, literal or RAM operand two.
// RULE20: parity flag always tracks the accumulator's set-bit count.
// RULE21: B register is multiply/divide operand and general scratch.
// RULE22: guard bit 1 enables both checks; clear means no violation output.
// RULE23: waterline is 0x7ff minus the setting; zero setting disables it.
// RULE24: waterline flag sets above waterline; clears by software below it.
// RULE25: move below stack base is ignored and sets bottom flag.
`timescale 1ns/1ps
module core_pointer_config_registers (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Special-register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Datapath controls
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic i_pc_advance,
  input wire logic [1:0] i_instr_len,
  input wire logic i_pc_jump,
  input wire logic [15:0] i_pc_target,
  input wire logic i_opcode_load,
  input wire logic [7:0] i_opcode,
  input wire logic i_acc_wr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_b_wr,
  input wire logic [7:0] i_b_wdata,
  input wire logic [2:0] i_bank_reg,
  input wire logic i_bank_wr,
  input wire logic [7:0] i_bank_wdata,
  input wire logic i_op_start,
  input wire logic i_src_is_bank,
  // Core state
  output logic [15:0] o_data_pointer,
  output logic [10:0] o_stack_addr,
  output logic [15:0] o_program_counter,
  output logic [7:0] o_opcode,
  output logic [7:0] o_accumulator,
  output logic [7:0] o_b_reg,
  output logic o_parity,
  output logic [7:0] o_bank_rdata,
  output logic [1:0] o_op_cycles,
  // Configuration
  output logic o_uart_extras_on,
  output logic o_serial_port_choice,
  output logic o_carrier_modulation_on,
  output logic o_xram_access_on,
  // Stack guard events
  output logic o_guard_irq,
  output logic o_guard_reset
);
  logic [7:0] dp_lo_ff, dp_hi_ff, stack_lo_ff, cfg_ff, acc_ff, b_ff, opcode_ff;
  logic [7:0] rdata_ff, bank_rdata_ff, nxt_acc, nxt_rdata;
  logic [2:0] stack_hi_ff, base_ff, nxt_base;
  logic [4:0] wtr_ff;
  logic [6:0] psw_ff;
  logic [15:0] pc_ff;
  logic [10:0] stack_addr, cand, level, nxt_stack;
  logic [1:0] cycles_ff;
  logic sh_rsv_ff, sb_flag_ff, wtr_hit_ff, mode_ff, guard_ff;
  logic xram_ff, hit_ff, irq_ff, rst_ff, over_ff, nxt_hit;
  logic move, below, over;
  logic [7:0] bank_mem [core_ptr_pkg::BANK_WORDS];

  wire wr_lo = i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_STACK_LOW;
  wire wr_hi = i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_STACK_HIGH;
  wire wr_guard = i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_GUARD;

  assign stack_addr = {stack_hi_ff, stack_lo_ff};
  assign level = core_ptr_pkg::STACK_TOP - {6'h00, wtr_ff}; // RULE23

  // Software moves win over push/pop in the same cycle
  always_comb begin
    nxt_base = base_ff;
    cand = stack_addr;
    move = 1'b0;
    if (wr_lo || wr_hi) begin
      move = 1'b1;
      if (wr_lo) cand[7:0] = i_sfr_wdata; // RULE2
      if (wr_hi) begin
        cand[10:8] = i_sfr_wdata[2:0]; // RULE3
        nxt_base = i_sfr_wdata[core_ptr_pkg::SH_BASE_LSB +: 3]; // RULE4
      end
    end else if (i_stack_push) begin
      move = 1'b1;
      cand = (stack_addr == core_ptr_pkg::STACK_TOP) ? {base_ff, 8'h00} : stack_addr + 11'h001;
    end else if (i_stack_pop) begin
      move = 1'b1;
      cand = stack_addr - 11'h001;
    end
    below = guard_ff && move && cand < {nxt_base, 8'h00}; // RULE25 RULE22
    nxt_stack = below ? stack_addr : cand; // RULE25
  end

  assign over = guard_ff && wtr_ff != 5'h00 && stack_addr > level; // RULE22 RULE23

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      stack_lo_ff <= core_ptr_pkg::RST_STACK_LOW; // RULE2
      stack_hi_ff <= core_ptr_pkg::RST_STACK_HI3; // RULE3
      base_ff <= core_ptr_pkg::RST_BASE; // RULE4
      sh_rsv_ff <= core_ptr_pkg::RST_SH_RSV; // RULE5
    end else begin
      {stack_hi_ff, stack_lo_ff} <= nxt_stack;
      base_ff <= nxt_base;
      if (wr_hi) sh_rsv_ff <= i_sfr_wdata[core_ptr_pkg::SH_RSV_BIT];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      sb_flag_ff <= 1'b0;
      wtr_hit_ff <= 1'b0;
    end else begin
      if (below) sb_flag_ff <= 1'b1; // RULE25
      else if (wr_hi && !i_sfr_wdata[core_ptr_pkg::SH_FLAG_BIT]) sb_flag_ff <= 1'b0;
      if (over) wtr_hit_ff <= 1'b1; // RULE24
      else if (wr_guard && !i_sfr_wdata[core_ptr_pkg::GC_FLAG_BIT] && stack_addr < level) wtr_hit_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      wtr_ff <= core_ptr_pkg::RST_WTR; // RULE6
      mode_ff <= 1'b0; // RULE7
      guard_ff <= 1'b0; // RULE22
    end else if (wr_guard) begin
      wtr_ff <= i_sfr_wdata[core_ptr_pkg::GC_WTR_LSB +: 5]; // RULE6
      mode_ff <= i_sfr_wdata[core_ptr_pkg::GC_MODE_BIT]; // RULE7
      guard_ff <= i_sfr_wdata[core_ptr_pkg::GC_EN_BIT]; // RULE22
    end
  end

  // One pulse per violation: on a bottom hit or on crossing the waterline
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      over_ff <= 1'b0;
      irq_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      over_ff <= over;
      irq_ff <= (below || (over && !over_ff)) && !mode_ff; // RULE7
      rst_ff <= (below || (over && !over_ff)) && mode_ff; // RULE7
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      dp_lo_ff <= 8'h00; // RULE1
      dp_hi_ff <= 8'h00; // RULE1
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == core_ptr_pkg::ADDR_DP_LO) dp_lo_ff <= i_sfr_wdata;
      if (i_sfr_addr == core_ptr_pkg::ADDR_DP_HI) dp_hi_ff <= i_sfr_wdata;
    end
  end

  // Reserved setup bits are stored as written; the core only reads 6..4 and 1..0
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      cfg_ff <= core_ptr_pkg::RST_CORE_SETUP; // RULE8 RULE13
      xram_ff <= |core_ptr_pkg::RST_CORE_SETUP[1:0];
    end else if (i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_CORE_SETUP) begin
      cfg_ff <= i_sfr_wdata; // RULE9 RULE10 RULE11
      xram_ff <= |i_sfr_wdata[1:0]; // RULE13
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) pc_ff <= core_ptr_pkg::RST_PC; // RULE14
    else if (i_pc_jump) pc_ff <= i_pc_target; // RULE15
    else if (i_pc_advance) pc_ff <= pc_ff + {14'h0000, i_instr_len}; // RULE14
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) opcode_ff <= 8'h00;
    else if (i_opcode_load) opcode_ff <= i_opcode; // RULE16
  end

  // Datapath result takes priority over a same-cycle register write
  always_comb begin
    nxt_acc = acc_ff;
    if (i_acc_wr) nxt_acc = i_acc_wdata;
    else if (i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_ACCUM) nxt_acc = i_sfr_wdata;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      acc_ff <= 8'h00;
      psw_ff <= 7'h00;
      b_ff <= 8'h00;
      o_parity <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      o_parity <= ^nxt_acc; // RULE20
      if (i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_STATUS_WORD) psw_ff <= i_sfr_wdata[7:1]; // RULE18
      if (i_b_wr) b_ff <= i_b_wdata; // RULE21
      else if (i_sfr_wr && i_sfr_addr == core_ptr_pkg::ADDR_B_REG) b_ff <= i_sfr_wdata; // RULE21
    end
  end

  wire [4:0] bank_addr = {psw_ff[core_ptr_pkg::BANK_SEL_LSB - 1 +: 2], i_bank_reg}; // RULE17 RULE18

  // Bank storage has no reset, like the RAM it stands in for
  always_ff @(posedge i_core_clk) begin
    if (i_bank_wr) bank_mem[bank_addr] <= i_bank_wdata; // RULE17
    bank_rdata_ff <= bank_mem[bank_addr];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) cycles_ff <= core_ptr_pkg::CYC_BANK_OP;
    else if (i_op_start) cycles_ff <= i_src_is_bank ? core_ptr_pkg::CYC_BANK_OP : core_ptr_pkg::CYC_OTHER_OP; // RULE19
  end

  always_comb begin
    nxt_hit = 1'b1;
    unique case (i_sfr_addr)
      core_ptr_pkg::ADDR_STACK_LOW: nxt_rdata = stack_lo_ff;
      core_ptr_pkg::ADDR_DP_LO: nxt_rdata = dp_lo_ff;
      core_ptr_pkg::ADDR_DP_HI: nxt_rdata = dp_hi_ff;
      core_ptr_pkg::ADDR_CORE_SETUP: nxt_rdata = cfg_ff;
      core_ptr_pkg::ADDR_STACK_HIGH: nxt_rdata = {sh_rsv_ff, sb_flag_ff, base_ff, stack_hi_ff};
      core_ptr_pkg::ADDR_GUARD: nxt_rdata = {wtr_ff, mode_ff, guard_ff, wtr_hit_ff};
      core_ptr_pkg::ADDR_STATUS_WORD: nxt_rdata = {psw_ff, o_parity}; // RULE20
      core_ptr_pkg::ADDR_ACCUM: nxt_rdata = acc_ff;
      core_ptr_pkg::ADDR_B_REG: nxt_rdata = b_ff;
      default: begin
        nxt_rdata = 8'h00;
        nxt_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rdata_ff <= 8'h00;
      hit_ff <= 1'b0;
    end else begin
      rdata_ff <= i_sfr_rd ? nxt_rdata : 8'h00;
      hit_ff <= i_sfr_rd && nxt_hit;
    end
  end

  assign o_sfr_rdata = rdata_ff;
  assign o_sfr_hit = hit_ff;
  assign o_data_pointer = {dp_hi_ff, dp_lo_ff}; // RULE1
  assign o_stack_addr = {stack_hi_ff, stack_lo_ff};
  assign o_program_counter = pc_ff;
  assign o_opcode = opcode_ff;
  assign o_accumulator = acc_ff;
  assign o_b_reg = b_ff;
  assign o_bank_rdata = bank_rdata_ff;
  assign o_op_cycles = cycles_ff;
  assign o_uart_extras_on = cfg_ff[core_ptr_pkg::CS_UART_BIT];
  assign o_serial_port_choice = cfg_ff[core_ptr_pkg::CS_SERIAL_BIT];
  assign o_carrier_modulation_on = cfg_ff[core_ptr_pkg::CS_MOD_BIT];
  assign o_xram_access_on = xram_ff;
  assign o_guard_irq = irq_ff;
  assign o_guard_reset = rst_ff;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_bottom_hit;
    below ##1 (sb_flag_ff && $stable(stack_addr));
  endsequence

  chk_pc_step: assert property (i_pc_advance && !i_pc_jump |=> pc_ff == $past(pc_ff) + {14'h0000, $past(i_instr_len)}) // RULE14
    else $error("program counter advance wrong");
  chk_pc_hold: assert property (!i_pc_advance && !i_pc_jump |=> $stable(pc_ff)) // RULE15
    else $error("program counter changed without cause");
  chk_parity_track: assert property (o_parity == ^acc_ff) // RULE20
    else $error("parity does not match accumulator");
  chk_bottom_block: assert property (below |-> s_bottom_hit) // RULE25
    else $error("stack move below base not blocked");
  chk_wtr_set: assert property (over |=> wtr_hit_ff) // RULE24
    else $error("waterline flag not set");
  chk_wtr_hold: assert property (wtr_hit_ff && stack_addr >= level |=> wtr_hit_ff) // RULE24
    else $error("waterline flag cleared above waterline");
  chk_guard_off: assert property (!guard_ff |=> !o_guard_irq && !o_guard_reset) // RULE22
    else $error("violation output with guard off");
  chk_resp_sel: assert property (o_guard_reset |-> $past(mode_ff) && !o_guard_irq) // RULE7
    else $error("reset response with interrupt mode");
  chk_op_cycles: assert property (i_op_start && i_src_is_bank |=> o_op_cycles == core_ptr_pkg::CYC_BANK_OP) // RULE19
    else $error("bank operand cycle count wrong");
  chk_xram_gate: assert property (o_xram_access_on == |cfg_ff[1:0]) // RULE13
    else $error("external RAM enable mismatch");
endmodule // core_pointer_config_registers

// ==== hw/core_ptr_pkg.sv ====
package core_ptr_pkg;
  // Special-register addresses
  localparam logic [7:0] ADDR_STACK_LOW = 8'h81;
  localparam logic [7:0] ADDR_DP_LO = 8'h82;
  localparam logic [7:0] ADDR_DP_HI = 8'h83;
  localparam logic [7:0] ADDR_CORE_SETUP = 8'haf;
  localparam logic [7:0] ADDR_STACK_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_GUARD = 8'hbf;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_ACCUM = 8'he0;
  localparam logic [7:0] ADDR_B_REG = 8'hf0;
  // Reset values
  localparam logic [7:0] RST_STACK_LOW = 8'h00;
  localparam logic [2:0] RST_STACK_HI3 = 3'h1;
  localparam logic [2:0] RST_BASE = 3'h1;
  localparam logic RST_SH_RSV = 1'b1;
  localparam logic [7:0] RST_CORE_SETUP = 8'h81;
  localparam logic [4:0] RST_WTR = 5'h00;
  localparam logic [15:0] RST_PC = 16'h0000;
  // Field positions
  localparam int SH_RSV_BIT = 7;
  localparam int SH_FLAG_BIT = 6;
  localparam int SH_BASE_LSB = 3;
  localparam int GC_WTR_LSB = 3;
  localparam int GC_MODE_BIT = 2;
  localparam int GC_EN_BIT = 1;
  localparam int GC_FLAG_BIT = 0;
  localparam int CS_UART_BIT = 6;
  localparam int CS_SERIAL_BIT = 5;
  localparam int CS_MOD_BIT = 4;
  localparam int BANK_SEL_LSB = 3;
  // Stack and bank geometry
  localparam logic [10:0] STACK_TOP = 11'h7ff;
  localparam int BANK_WORDS = 32;
  // Execution cycle counts
  localparam logic [1:0] CYC_BANK_OP = 2'h1;
  localparam logic [1:0] CYC_OTHER_OP = 2'h2;
endpackage

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic adv = 1'b0;
  logic [1:0] len = 2'h1;
  logic jmp = 1'b0;
  logic [15:0] tgt = 16'h0000;
  logic opl = 1'b0;
  logic acc_wr = 1'b0;
  logic b_wr = 1'b0;
  logic bank_wr = 1'b0;
  logic [7:0] dwr = 8'h00;
  logic op_start = 1'b0;
  logic src_bank = 1'b0;
  logic [2:0] breg = 3'h2;
  logic [7:0] cfg [5] = '{8'hc1, 8'ha1, 8'h91, 8'h80, 8'h82};
  logic [7:0] rdata, opcode, acc, b_reg, bank_rdata;
  logic [15:0] dp, pc;
  logic [10:0] sp;
  logic [1:0] opc;
  logic hit, par, uart_x, ser, modu, xram, g_irq, g_rst;
  int bad_count = 0;
  int check_count = 0;

  core_pointer_config_registers uut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_sfr_addr(addr), .i_sfr_wr(wr_s), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd_s), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_stack_push(push), .i_stack_pop(pop),
    .i_pc_advance(adv), .i_instr_len(len), .i_pc_jump(jmp), .i_pc_target(tgt), .i_opcode_load(opl),
    .i_opcode(dwr), .i_acc_wr(acc_wr), .i_acc_wdata(dwr), .i_b_wr(b_wr), .i_b_wdata(dwr),
    .i_bank_reg(breg), .i_bank_wr(bank_wr), .i_bank_wdata(dwr), .i_op_start(op_start),
    .i_src_is_bank(src_bank), .o_data_pointer(dp), .o_stack_addr(sp), .o_program_counter(pc),
    .o_opcode(opcode), .o_accumulator(acc), .o_b_reg(b_reg), .o_parity(par), .o_bank_rdata(bank_rdata),
    .o_op_cycles(opc), .o_uart_extras_on(uart_x), .o_serial_port_choice(ser),
    .o_carrier_modulation_on(modu), .o_xram_access_on(xram), .o_guard_irq(g_irq), .o_guard_reset(g_rst)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask

  // Read data stands for one cycle only, so it is sampled at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk(rdata, exp);
    chk(hit, h);
  endtask

  // One-cycle stack move; the guard pulse is looked at in the cycle it stands
  task automatic mv(input logic up, input logic irq, input logic rst);
    @(negedge clk);
    push = up;
    pop = ~up;
    @(negedge clk);
    push = 1'b0;
    pop = 1'b0;
    chk(g_irq, irq);
    chk(g_rst, rst);
  endtask

  task automatic strobe(ref logic s, input logic [7:0] d);
    @(negedge clk);
    dwr = d;
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    chk(sp, 11'h100);
    chk(pc, 16'h0000);
    chk(dp, 16'h0000);
    chk({uart_x, ser, modu, xram}, 4'h1);
    rd(8'h81, 8'h00, 1'b1);
    rd(8'h83, 8'h00, 1'b1);
    rd(8'hb7, 8'h89, 1'b1);
    rd(8'hbf, 8'h00, 1'b1);
    rd(8'haf, 8'h81, 1'b1);
    rd(8'h90, 8'h00, 1'b0);
    $display("reset test finished");
    wr(8'h83, 8'h12);
    wr(8'h82, 8'h34);
    chk(dp, 16'h1234);
    rd(8'h82, 8'h34, 1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(8'haf, cfg[i]);
      chk({uart_x, ser, modu, xram}, {cfg[i][6:4], |cfg[i][1:0]});
      rd(8'haf, cfg[i], 1'b1);
    end
    $display("setup test finished");
    for (int i = 1; i < 4; i++) begin
      len = i[1:0];
      strobe(adv, 8'h00);
    end
    chk(pc, 16'h0006);
    tgt = 16'h0abc;
    adv = 1'b1;
    strobe(jmp, 8'h00);
    adv = 1'b0;
    chk(pc, 16'h0abc);
    strobe(opl, 8'ha5);
    chk(opcode, 8'ha5);
    $display("counter test finished");
    strobe(acc_wr, 8'h07);
    chk(acc, 8'h07);
    chk(par, 1'b1);
    wr(8'hd0, 8'h18);
    rd(8'hd0, 8'h19, 1'b1);
    strobe(bank_wr, 8'h5a);
    wr(8'hd0, 8'h00);
    strobe(bank_wr, 8'h11);
    wr(8'hd0, 8'h18);
    @(negedge clk);
    chk(bank_rdata, 8'h5a);
    wr(8'hd0, 8'h00);
    @(negedge clk);
    chk(bank_rdata, 8'h11);
    breg = 3'h5;
    strobe(bank_wr, 8'h77);
    @(negedge clk);
    chk(bank_rdata, 8'h77);
    src_bank = 1'b1;
    strobe(op_start, 8'h00);
    chk(opc, 2'h1);
    src_bank = 1'b0;
    strobe(op_start, 8'h00);
    chk(opc, 2'h2);
    strobe(b_wr, 8'h3c);
    chk(b_reg, 8'h3c);
    rd(8'hf0, 8'h3c, 1'b1);
    $display("datapath test finished");
    mv(1'b0, 1'b0, 1'b0);
    chk(sp, 11'h0ff);
    wr(8'hb7, 8'h89);
    // Put the pointer back on the base so the next pop is the one that trips
    wr(8'h81, 8'h00);
    chk(sp, 11'h100);
    wr(8'hbf, 8'h02);
    mv(1'b0, 1'b1, 1'b0);
    chk(sp, 11'h100);
    rd(8'hb7, 8'hc9, 1'b1);
    wr(8'hb7, 8'h89);
    rd(8'hb7, 8'h89, 1'b1);
    wr(8'hbf, 8'h06);
    mv(1'b0, 1'b0, 1'b1);
    wr(8'hbf, 8'h0a);
    wr(8'hb7, 8'h8f);
    wr(8'h81, 8'hfe);
    chk(sp, 11'h7fe);
    // The waterline compare looks at the stored pointer, so its pulse comes one cycle later
    mv(1'b1, 1'b0, 1'b0);
    @(negedge clk);
    chk(g_irq, 1'b1);
    chk(g_rst, 1'b0);
    rd(8'hbf, 8'h0b, 1'b1);
    wr(8'hbf, 8'h0a);
    rd(8'hbf, 8'h0b, 1'b1);
    mv(1'b1, 1'b0, 1'b0);
    chk(sp, 11'h100);
    wr(8'hbf, 8'h0a);
    rd(8'hbf, 8'h0a, 1'b1);
    $display("stack guard test finished");
    conclude();
  end

  // Watchdog in case the sequence stalls
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule // tb_top
